// ### core/ftu_pkg.sv
/*
  Package for the four-channel timer unit: register addresses, field
  positions, mode codes, the prescale table and the sampled-pin carrier.
  Assumes a 4-bit register address and an 8-bit data bus.
*/
package ftu_pkg;

  localparam int NUM_TIMERS = 4;
  localparam int NUM_AUX = 2;

  // register addresses on the peripheral bus
  localparam logic [3:0] ADDR_AB_CTRL = 4'h9;
  localparam logic [3:0] ADDR_CD_CTRL = 4'ha;
  localparam logic [3:0] ADDR_DATA_A = 4'hc;
  localparam logic [3:0] ADDR_DATA_B = 4'hd;
  localparam logic [3:0] ADDR_DATA_C = 4'he;
  localparam logic [3:0] ADDR_DATA_D = 4'hf;

  // timer_ab_control fields
  localparam int AB_A_LSB = 0;
  localparam int AB_B_LSB = 4;
  // timer_cd_control fields
  localparam int CD_D_LSB = 0;
  localparam int CD_FORCE_B = 3;
  localparam int CD_C_LSB = 4;
  localparam int CD_FORCE_A = 7;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [7:0] PSC_ZERO = 8'h00;
  localparam logic [7:0] PSC_STEP = 8'h01;
  localparam logic [3:0] CODE_STOP = 4'h0;
  localparam logic [3:0] CODE_EVENT = 4'h8;
  localparam int MODE_TOP = 3;

  typedef enum logic [1:0] {
    mode_stopped,
    mode_delay,
    mode_event,
    mode_pulse
  } ftu_mode_t;

  // one snapshot of the asynchronous pins
  typedef struct packed {
    logic wr_b;
    logic rd_b;
    logic [3:0] addr;
    logic [7:0] data;
    logic aux_line4;
    logic aux_line3;
  } ftu_pins_t;

  localparam ftu_pins_t PINS_IDLE = '{wr_b: 1'b1, rd_b: 1'b1,
                                      addr: 4'h0, data: 8'h00,
                                      aux_line4: 1'b0, aux_line3: 1'b0};

  function automatic ftu_mode_t decode_mode(input logic [3:0] code);
    if (code == CODE_STOP) begin
      return mode_stopped;
    end else if (code == CODE_EVENT) begin
      return mode_event;
    end else if (code[MODE_TOP]) begin
      return mode_pulse;
    end
    return mode_delay;
  endfunction

  function automatic logic [7:0] prescale_div(input logic [2:0] sel);
    case (sel)
      3'h1: return 8'h04;
      3'h2: return 8'h0a;
      3'h3: return 8'h10;
      3'h4: return 8'h32;
      3'h5: return 8'h40;
      3'h6: return 8'h64;
      3'h7: return 8'hc8;
      default: return 8'h01;
    endcase
  endfunction

endpackage

// ### core/ftu_pin_sync.sv
/*
  Two-flop synchroniser for the sampled pin bundle of the timer unit.
  Assumes the pins are asynchronous to ref_clk and stable for several
  clocks around each strobe edge, as bus timing guarantees.
*/
`timescale 1ns/1ps
module ftu_pin_sync (
  input wire logic ref_clk, // timer clock
  input wire logic rst_b, // async reset, active low
  input wire logic clk_en, // freezes the flops while low
  input wire ftu_pkg::ftu_pins_t pins_raw, // pins straight from the pads
  output ftu_pkg::ftu_pins_t pins_sync // pins after two flops
);

  ftu_pkg::ftu_pins_t stage1;

  // stage1 feeds only the second flop
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= ftu_pkg::PINS_IDLE;
      pins_sync <= ftu_pkg::PINS_IDLE;
    end else if (clk_en) begin
      stage1 <= pins_raw;
      pins_sync <= stage1;
    end
  end

endmodule

// ### core/ftu_timer_unit.sv
/*
  Four 8-bit reloading down-counter timers with prescalers and toggling
  outputs, plus the register port through which the host controls them.
  Assumes the host drives active-low write and read strobes with address
  and data set up around them, and that the interrupt controller beside
  this block supplies the edge bits of general lines 4 and 3.
*/
// What this block does
// (RULE1) four timers: A and B full function, C and D delay only
// (RULE2) stopped timer holds count, loses prescaler residue, write reloads
// (RULE3) delay mode: prescaler runs, one count pulse per prescale period
// (RULE4) count pulse decrements; at 01 it reloads and emits a time-out
// (RULE5) time-out signals the interrupt channel and toggles the output
// (RULE6) counters are 8-bit down counters readable any time
// (RULE7) read returns the value latched when the read strobe fell
// (RULE8) write loads counter only if stopped; running takes it at reload
// (RULE9) host must not write a running timer while its count is 01
// (RULE10) reload 01 times out every pulse, 00 every 256 pulses
// (RULE11) prescale change mid-run: first time-out within 1 to 200 clocks
// (RULE12) timer A gated by line 4, timer B by line 3; interrupts stay
// (RULE13) pulse-width mode runs only while aux input is at active level
// (RULE14) pulse-width mode flips the aux interrupt edge to mark pulse end
// (RULE15) entering or leaving pulse-width mode may raise an interrupt
// (RULE16) event mode bypasses prescaler; active aux edges decrement
// (RULE17) source holds aux at each level for at least 4 timer clocks
// (RULE18) device reset drives every timer output low
// (RULE19) device reset leaves data registers and counters unchanged
// (RULE20) output-reset bit holds A or B output low only during the write
// (RULE21) A/B code: 0 stop, 1-7 delay, 8 event, 9-15 pulse width
// (RULE22) outputs of timers C and D serve as serial baud clocks
// (RULE23) A/B control: A code in low nibble, B code in high nibble
// (RULE24) C/D codes are 3 bits: 0 stops, others delay with same prescales
`timescale 1ns/1ps
module ftu_timer_unit (
  input wire logic ref_clk, // timer clock, 100 MHz
  input wire logic rst_b, // device reset, async, active low
  input wire logic clk_en, // freezes all state while low
  input wire logic wr_strobe_b, // chip-enable write strobe, active low
  input wire logic rd_strobe_b, // chip-enable read strobe, active low
  input wire logic [3:0] addr, // register address
  input wire logic [7:0] data_in, // data bus, host to block
  output logic [7:0] data_out, // data bus, block to host
  output logic data_oe, // high while the block drives the data bus
  input wire logic aux_line4, // general input line 4, timer A aux
  input wire logic aux_line3, // general input line 3, timer B aux
  input wire logic edge_bit_line4, // edge bit of line 4, 1 = rising
  input wire logic edge_bit_line3, // edge bit of line 3, 1 = rising
  output logic [1:0] aux_irq_level, // to line 4/3 interrupt channels
  output logic [3:0] timeout_pulse, // to timer D..A interrupt channels
  output logic [3:0] timer_outputs // toggling outputs, D..A
);

  ftu_pkg::ftu_pins_t pins_raw;
  ftu_pkg::ftu_pins_t pins;
  logic wr_b_prev;
  logic rd_b_prev;
  logic wr_rise;
  logic wr_low;
  logic rd_fall;

  logic [7:0] timer_ab_control;
  logic [2:0] code_c;
  logic [2:0] code_d;
  logic [3:0] code [ftu_pkg::NUM_TIMERS];
  ftu_pkg::ftu_mode_t mode [ftu_pkg::NUM_TIMERS];
  logic [7:0] div [ftu_pkg::NUM_TIMERS];

  logic [7:0] reload [ftu_pkg::NUM_TIMERS];
  logic [7:0] counter [ftu_pkg::NUM_TIMERS];
  logic [7:0] psc [ftu_pkg::NUM_TIMERS];
  logic [3:0] load;
  logic [3:0] run_psc;
  logic [3:0] psc_done;
  logic [3:0] cnt_pulse;
  logic [3:0] expire;
  logic [3:0] force_low;

  logic [1:0] aux_level;
  logic [1:0] edge_bit;
  logic [1:0] gate;
  logic [1:0] gate_prev;
  logic [1:0] gate_rise;
  logic [1:0] pulse_mode;
  logic [7:0] next_read;
  localparam logic [7:0] COUNT_STEP = ftu_pkg::COUNT_ONE;

  assign pins_raw = '{wr_b: wr_strobe_b, rd_b: rd_strobe_b, addr: addr,
                      data: data_in, aux_line4: aux_line4,
                      aux_line3: aux_line3};

  ftu_pin_sync u_pin_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .pins_raw(pins_raw),
    .pins_sync(pins)
  );

  // strobe edges are taken from the synchronised copies
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_b_prev <= 1'b1;
      rd_b_prev <= 1'b1;
    end else if (clk_en) begin
      wr_b_prev <= pins.wr_b;
      rd_b_prev <= pins.rd_b;
    end
  end

  // writes commit on the rising strobe, when address and data are settled
  assign wr_rise = pins.wr_b & ~wr_b_prev;
  assign wr_low = ~pins.wr_b;
  assign rd_fall = ~pins.rd_b & rd_b_prev;

  // control registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_ab_control <= ftu_pkg::CTRL_RESET;
    end else if (clk_en) begin
      if (wr_rise && pins.addr == ftu_pkg::ADDR_AB_CTRL) begin
        timer_ab_control <= pins.data; // RULE23
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      code_c <= ftu_pkg::CTRL_RESET[2:0];
      code_d <= ftu_pkg::CTRL_RESET[2:0];
    end else if (clk_en) begin
      if (wr_rise && pins.addr == ftu_pkg::ADDR_CD_CTRL) begin
        code_c <= pins.data[ftu_pkg::CD_C_LSB +: 3];
        code_d <= pins.data[ftu_pkg::CD_D_LSB +: 3];
      end
    end
  end

  // C and D get a zero top bit, so they never reach event or pulse width
  assign code[0] = timer_ab_control[ftu_pkg::AB_A_LSB +: 4]; // RULE23
  assign code[1] = timer_ab_control[ftu_pkg::AB_B_LSB +: 4]; // RULE23
  assign code[2] = {1'b0, code_c}; // RULE24 RULE1
  assign code[3] = {1'b0, code_d}; // RULE24 RULE1

  always_comb begin
    for (int i = 0; i < ftu_pkg::NUM_TIMERS; i++) begin
      mode[i] = ftu_pkg::decode_mode(code[i]); // RULE21
      div[i] = ftu_pkg::prescale_div(code[i][2:0]); // RULE21
    end
  end

  // output force is a level, held only while the write strobe is low
  always_comb begin
    force_low = 4'h0;
    if (wr_low && pins.addr == ftu_pkg::ADDR_CD_CTRL) begin
      force_low[0] = pins.data[ftu_pkg::CD_FORCE_A]; // RULE20
      force_low[1] = pins.data[ftu_pkg::CD_FORCE_B]; // RULE20
    end
  end

  // per-timer data register write strobes
  always_comb begin
    load[0] = wr_rise && pins.addr == ftu_pkg::ADDR_DATA_A;
    load[1] = wr_rise && pins.addr == ftu_pkg::ADDR_DATA_B;
    load[2] = wr_rise && pins.addr == ftu_pkg::ADDR_DATA_C;
    load[3] = wr_rise && pins.addr == ftu_pkg::ADDR_DATA_D;
  end

  // auxiliary lines: A uses line 4, B uses line 3
  assign aux_level[0] = pins.aux_line4; // RULE12
  assign aux_level[1] = pins.aux_line3; // RULE12
  assign edge_bit[0] = edge_bit_line4;
  assign edge_bit[1] = edge_bit_line3;

  always_comb begin
    for (int i = 0; i < ftu_pkg::NUM_AUX; i++) begin
      // active level follows the edge bit, so flipping it can count
      gate[i] = edge_bit[i] ? aux_level[i] : ~aux_level[i]; // RULE13
      gate_rise[i] = gate[i] & ~gate_prev[i]; // RULE16
      pulse_mode[i] = mode[i] == ftu_pkg::mode_pulse;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      gate_prev <= 2'b00;
    end else if (clk_en) begin
      gate_prev <= gate;
    end
  end

  // interrupt level seen by lines 4/3: rises on the normal active edge,
  // or on the opposite edge while in pulse-width mode; a mode change can
  // itself make a rising edge here, which the channel may take as an event
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_irq_level <= 2'b00;
    end else if (clk_en) begin
      for (int i = 0; i < ftu_pkg::NUM_AUX; i++) begin
        aux_irq_level[i] <= gate[i] ^ pulse_mode[i]; // RULE14 RULE15
      end
    end
  end

  // count pulse selection
  always_comb begin
    for (int i = 0; i < ftu_pkg::NUM_TIMERS; i++) begin
      run_psc[i] = 1'b0;
      cnt_pulse[i] = 1'b0;
      case (mode[i])
        ftu_pkg::mode_delay: begin
          run_psc[i] = 1'b1; // RULE3
        end
        ftu_pkg::mode_pulse: begin
          if (i < ftu_pkg::NUM_AUX) begin
            run_psc[i] = gate[i % ftu_pkg::NUM_AUX]; // RULE13
          end
        end
        ftu_pkg::mode_event: begin
          if (i < ftu_pkg::NUM_AUX) begin
            cnt_pulse[i] = gate_rise[i % ftu_pkg::NUM_AUX]; // RULE16
          end
        end
        default: begin
          run_psc[i] = 1'b0; // RULE2
        end
      endcase
      // >= covers a divide that shrank below the running count
      psc_done[i] = run_psc[i] && psc[i] >= div[i] - ftu_pkg::PSC_STEP;
      if (psc_done[i]) begin
        cnt_pulse[i] = 1'b1; // RULE3
      end
      expire[i] = cnt_pulse[i] && counter[i] == ftu_pkg::COUNT_ONE;
    end
  end

  // prescalers: a stopped or gated-off prescaler drops its residue
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < ftu_pkg::NUM_TIMERS; i++) begin
        psc[i] <= ftu_pkg::PSC_ZERO;
      end
    end else if (clk_en) begin
      for (int i = 0; i < ftu_pkg::NUM_TIMERS; i++) begin
        if (!run_psc[i] || psc_done[i]) begin
          psc[i] <= ftu_pkg::PSC_ZERO; // RULE2 RULE11
        end else begin
          psc[i] <= psc[i] + ftu_pkg::PSC_STEP; // RULE3
        end
      end
    end
  end

  // reload values and counters have no reset: a device reset keeps them
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      for (int i = 0; i < ftu_pkg::NUM_TIMERS; i++) begin
        if (load[i]) begin
          reload[i] <= pins.data; // RULE8 RULE19
        end
      end
    end
  end

  // a running-timer write coinciding with the 01 reload takes the old
  // reload value; the host is expected to avoid that moment
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      for (int i = 0; i < ftu_pkg::NUM_TIMERS; i++) begin
        if (load[i] && mode[i] == ftu_pkg::mode_stopped) begin
          counter[i] <= pins.data; // RULE2 RULE8
        end else if (expire[i]) begin
          counter[i] <= reload[i]; // RULE4 RULE9 RULE10
        end else if (cnt_pulse[i]) begin
          // 00 wraps to ff, giving 256 pulses per time-out
          counter[i] <= counter[i] - COUNT_STEP; // RULE4 RULE6 RULE10
        end
      end
    end
  end

  // time-out pulses toward the interrupt channels
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      timeout_pulse <= 4'h0;
    end else if (clk_en) begin
      timeout_pulse <= expire; // RULE5
    end
  end

  // toggling outputs; C and D also clock the serial port baud logic
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_outputs <= 4'h0; // RULE18
    end else if (clk_en) begin
      for (int i = 0; i < ftu_pkg::NUM_TIMERS; i++) begin
        if (force_low[i]) begin
          timer_outputs[i] <= 1'b0; // RULE20
        end else if (expire[i]) begin
          timer_outputs[i] <= ~timer_outputs[i]; // RULE5 RULE22
        end
      end
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    case (pins.addr)
      ftu_pkg::ADDR_AB_CTRL: next_read = timer_ab_control;
      ftu_pkg::ADDR_CD_CTRL: begin
        next_read = ftu_pkg::READ_ZERO;
        next_read[ftu_pkg::CD_C_LSB +: 3] = code_c;
        next_read[ftu_pkg::CD_D_LSB +: 3] = code_d;
      end
      ftu_pkg::ADDR_DATA_A: next_read = counter[0]; // RULE6
      ftu_pkg::ADDR_DATA_B: next_read = counter[1]; // RULE6
      ftu_pkg::ADDR_DATA_C: next_read = counter[2]; // RULE6
      ftu_pkg::ADDR_DATA_D: next_read = counter[3]; // RULE6
      default: next_read = ftu_pkg::READ_ZERO;
    endcase
  end

  // the read latch freezes at the falling read strobe, so a counter that
  // moves during the host cycle cannot tear the byte on the bus
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_out <= ftu_pkg::READ_ZERO;
    end else if (clk_en) begin
      if (rd_fall) begin
        data_out <= next_read; // RULE7
      end
    end
  end

  assign data_oe = ~pins.rd_b & ~rd_b_prev;

endmodule

// ### verification/ftu_timer_unit_props.sv
/*
  Checker for the four-channel timer unit, bound to its top module.
  Assumes host strobes stay low or high for at least five clocks.
*/
`timescale 1ns/1ps
module ftu_timer_unit_props (
  input wire logic ref_clk, // timer clock
  input wire logic rst_b, // reset
  input wire logic clk_en, // run enable
  input wire logic wr_strobe_b, // write strobe
  input wire logic rd_strobe_b, // read strobe
  input wire logic [3:0] addr, // address
  input wire logic [7:0] data_in, // write data
  input wire logic [7:0] data_out, // read latch
  input wire logic data_oe, // bus drive
  input wire logic aux_line4, // aux a
  input wire logic aux_line3, // aux b
  input wire logic edge_bit_line4, // edge a
  input wire logic edge_bit_line3, // edge b
  input wire logic [1:0] aux_irq_level, // aux irq
  input wire logic [3:0] timeout_pulse, // time-outs
  input wire logic [3:0] timer_outputs // outputs
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  // sync lag is three clocks, so six samples cover a settled strobe
  sequence rd_cycle;
    rd_strobe_b ##1 (!rd_strobe_b && clk_en)[*6];
  endsequence
  sequence rd_unmapped;
    (!rd_strobe_b && clk_en && (addr < 4'h9 || addr == 4'hb))[*6];
  endsequence
  sequence force_wr(int bit_pos);
    (!wr_strobe_b && clk_en && addr == ftu_pkg::ADDR_CD_CTRL &&
     data_in[bit_pos])[*5];
  endsequence

  chk_reset_low:
    assert property (disable iff (1'b0) !rst_b |->
      (timer_outputs == 4'h0 && timeout_pulse == 4'h0))
    else $error("outputs not low in reset");
  chk_toggle_c:
    assert property ($changed(timer_outputs[2]) == timeout_pulse[2])
    else $error("timer c output moved without a time-out");
  chk_toggle_d:
    assert property ($changed(timer_outputs[3]) == timeout_pulse[3])
    else $error("timer d output moved without a time-out");
  chk_pulse_single:
    assert property (!(|(timeout_pulse & $past(timeout_pulse))))
    else $error("time-out pulse longer than one clock");
  chk_force_low_a:
    assert property (force_wr(ftu_pkg::CD_FORCE_A) |-> !timer_outputs[0])
    else $error("timer a output not forced low");
  chk_force_low_b:
    assert property (force_wr(ftu_pkg::CD_FORCE_B) |-> !timer_outputs[1])
    else $error("timer b output not forced low");
  chk_read_drive:
    assert property (rd_cycle |-> data_oe)
    else $error("bus not driven during read");
  chk_idle_float:
    assert property ((rd_strobe_b && clk_en)[*6] |-> !data_oe)
    else $error("bus driven with no read");
  chk_unmapped_zero:
    assert property (rd_unmapped |-> data_out == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind ftu_timer_unit ftu_timer_unit_props ftu_timer_unit_props_inst (
  .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
  .wr_strobe_b(wr_strobe_b), .rd_strobe_b(rd_strobe_b), .addr(addr),
  .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
  .aux_line4(aux_line4), .aux_line3(aux_line3),
  .edge_bit_line4(edge_bit_line4), .edge_bit_line3(edge_bit_line3),
  .aux_irq_level(aux_irq_level), .timeout_pulse(timeout_pulse),
  .timer_outputs(timer_outputs)
);

// ### verification/ftu_host_model.sv
/*
  Host processor model for the timer unit register port.
  Assumes inputs are driven on the falling edge of ref_clk.
*/
`timescale 1ns/1ps
module ftu_host_model (
  input wire logic ref_clk, // timer clock
  output logic wr_strobe_b, // write strobe
  output logic rd_strobe_b, // read strobe
  output logic [3:0] addr, // address
  output logic [7:0] data_in, // write data
  input wire logic [7:0] data_out, // read latch
  input wire logic data_oe // bus drive
);
  int stretch = 0;

  initial begin
    wr_strobe_b = 1'b1;
    rd_strobe_b = 1'b1;
    addr = 4'h0;
    data_in = 8'h00;
  end

  // released lines show the inverse so stale values cannot pass
  task automatic release_bus();
    repeat (4) @(negedge ref_clk);
    addr = ~addr;
    data_in = ~data_in;
    @(negedge ref_clk);
  endtask

  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
    addr = a;
    data_in = d;
    repeat (3) @(negedge ref_clk);
    wr_strobe_b = 1'b0;
    repeat (6 + stretch) @(negedge ref_clk);
    wr_strobe_b = 1'b1;
    release_bus();
  endtask

  task automatic read_reg(input logic [3:0] a, output logic [7:0] d,
                          output logic ok);
    int n;
    addr = a;
    ok = 1'b0;
    d = 8'h00;
    repeat (3) @(negedge ref_clk);
    rd_strobe_b = 1'b0;
    for (n = 0; n < 20 && !ok; n++) begin
      @(negedge ref_clk);
      if (data_oe === 1'b1) begin
        d = data_out;
        ok = 1'b1;
      end
    end
    repeat (3) @(negedge ref_clk);
    rd_strobe_b = 1'b1;
    release_bus();
  endtask
endmodule

// ### verification/tb.sv
/*
  Self-checking testbench for the four-channel timer unit.
  Assumes the host model and checker files are compiled before it.
*/
`timescale 1ns/1ps
module tb;
  logic ref_clk, rst_b, clk_en, wr_b, rd_b, aux4, aux3, eb4, eb3, oe;
  logic [3:0] addr, tp, touts;
  logic [7:0] din, dout;
  logic [1:0] irq;
  int fail_count = 0;
  int checks = 0;
  int divs[7] = '{4, 10, 16, 50, 64, 100, 200};

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  ftu_host_model ftu_host_model_inst (.ref_clk(ref_clk),
    .wr_strobe_b(wr_b), .rd_strobe_b(rd_b), .addr(addr), .data_in(din),
    .data_out(dout), .data_oe(oe));
  ftu_timer_unit ftu_timer_unit_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .clk_en(clk_en), .wr_strobe_b(wr_b), .rd_strobe_b(rd_b), .addr(addr),
    .data_in(din), .data_out(dout), .data_oe(oe), .aux_line4(aux4),
    .aux_line3(aux3), .edge_bit_line4(eb4), .edge_bit_line3(eb3),
    .aux_irq_level(irq), .timeout_pulse(tp), .timer_outputs(touts));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    ftu_host_model_inst.write_reg(a, d);
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a,
                        input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    ftu_host_model_inst.read_reg(a, d, ok);
    if (ok !== 1'b1) begin
      $display("Error %s: read not answered in time", what);
      fail_count++;
      report_and_stop();
    end
    chk(what, 16'(d), 16'(exp));
  endtask

  task automatic wait_pulse(input int i, output int n);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
      if (n > 3000) begin
        $display("Error time-out pulse %0d: none within limit", i);
        fail_count++;
        report_and_stop();
      end
    end while (tp[i] !== 1'b1);
  endtask

  // the first interval after a change is indeterminate, so skip it
  task automatic measure(input string what, input int i, input int exp);
    int n;
    logic o;
    wait_pulse(i, n);
    o = touts[i];
    wait_pulse(i, n);
    chk(what, 16'(n), 16'(exp));
    chk("output toggle", 16'(touts[i]), 16'(!o));
  endtask

  task automatic t_registers();
    rd_chk("ab control", ftu_pkg::ADDR_AB_CTRL, 8'h00);
    wr(ftu_pkg::ADDR_DATA_A, 8'h02);
    wr(ftu_pkg::ADDR_DATA_B, 8'h02);
    wr(ftu_pkg::ADDR_AB_CTRL, 8'h30);
    rd_chk("ab control", ftu_pkg::ADDR_AB_CTRL, 8'h30);
    wr(ftu_pkg::ADDR_AB_CTRL, 8'h00);
    rd_chk("unmapped", 4'h3, 8'h00);
    wr(ftu_pkg::ADDR_CD_CTRL, 8'h88);
    rd_chk("force bits", ftu_pkg::ADDR_CD_CTRL, 8'h00);
    $display("test registers done");
  endtask

  task automatic t_delay_codes();
    eb4 = 1'b1;
    aux4 = 1'b1;
    for (int k = 1; k < 16; k++) begin
      if (k != 8) begin
        wr(ftu_pkg::ADDR_AB_CTRL, 8'(k));
        measure("period a", 0, 2 * divs[(k % 8) - 1]);
      end
    end
    wr(ftu_pkg::ADDR_AB_CTRL, 8'h00);
    $display("test delay codes done");
  endtask

  task automatic t_reload_cd();
    int n;
    wr(ftu_pkg::ADDR_DATA_C, 8'h03);
    wr(ftu_pkg::ADDR_DATA_D, 8'h01);
    wr(ftu_pkg::ADDR_CD_CTRL, 8'h71);
    measure("period c", 2, 600);
    measure("period d", 3, 4);
    // write just after reload, far from a count of 01
    wait_pulse(2, n);
    ftu_host_model_inst.stretch = 20;
    wr(ftu_pkg::ADDR_DATA_C, 8'h05);
    ftu_host_model_inst.stretch = 0;
    measure("period c new", 2, 1000);
    wr(ftu_pkg::ADDR_CD_CTRL, 8'h70);
    wr(ftu_pkg::ADDR_DATA_D, 8'h00);
    wr(ftu_pkg::ADDR_CD_CTRL, 8'h71);
    measure("period d 256", 3, 1024);
    $display("test reload c d done");
  endtask

  task automatic t_event_b();
    int n;
    n = 0;
    eb3 = 1'b1;
    wr(ftu_pkg::ADDR_AB_CTRL, 8'h80);
    for (int k = 0; k < 54; k++) begin
      @(negedge ref_clk);
      aux3 = ((k / 6) % 2) == 1;
      if (tp[1] === 1'b1) begin
        n++;
      end
    end
    chk("event time-outs", 16'(n), 16'd2);
    wr(ftu_pkg::ADDR_AB_CTRL, 8'h00);
    $display("test event count done");
  endtask

  task automatic t_pulse_a();
    aux4 = 1'b0;
    wr(ftu_pkg::ADDR_DATA_A, 8'h10);
    wr(ftu_pkg::ADDR_AB_CTRL, 8'h09);
    aux4 = 1'b1;
    repeat (42) @(negedge ref_clk);
    chk("irq level active", 16'(irq[0]), 16'h0);
    aux4 = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk("irq level end", 16'(irq[0]), 16'h1);
    rd_chk("pulse width", ftu_pkg::ADDR_DATA_A, 8'h06);
    wr(ftu_pkg::ADDR_AB_CTRL, 8'h00);
    chk("irq level normal", 16'(irq[0]), 16'h0);
    $display("test pulse width done");
  endtask

  task automatic t_stop_reset();
    wr(ftu_pkg::ADDR_CD_CTRL, 8'h00);
    wr(ftu_pkg::ADDR_DATA_C, 8'h37);
    // a write made while the clock enable is low must be lost
    clk_en = 1'b0;
    wr(ftu_pkg::ADDR_DATA_C, 8'h12);
    clk_en = 1'b1;
    wr(ftu_pkg::ADDR_CD_CTRL, 8'h01);
    repeat (50) @(negedge ref_clk);
    rd_chk("stopped c", ftu_pkg::ADDR_DATA_C, 8'h37);
    rst_b = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("outputs in reset", 16'(touts), 16'h0);
    rst_b = 1'b1;
    rd_chk("c after reset", ftu_pkg::ADDR_DATA_C, 8'h37);
    $display("test stop and reset done");
  endtask

  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    aux4 = 1'b0;
    aux3 = 1'b0;
    eb4 = 1'b0;
    eb3 = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("outputs in reset", {8'h00, touts, tp}, 16'h0);
    rst_b = 1'b1;
    t_registers();
    t_delay_codes();
    t_reload_cd();
    t_event_b();
    t_pulse_a();
    t_stop_reset();
    report_and_stop();
  end
endmodule
